/* logic/cscc_regs.vh */
// opcode, mode and timing constants for the call and compare sequencer
`ifndef CSCC_REGS_VH
`define CSCC_REGS_VH
`define OP_PREFIX 8'hCE
`define OP_CALL_CZ_HI 6'h38
`define OP_CALL_SC_HI 4'hF
`define OP_CMP_AA 8'h30
`define OP_CMP_AB 8'h31
`define OP_CMP_AIMM 8'h32
`define OP_CMP_ASHORT 8'h33
`define OP_CMP_ALONG 8'h34
`define OP_CMP_APTR 8'h35
`define OP_CMP_AIX 8'h36
`define OP_CMP_AIY 8'h37
`define OP2_CMP_IXD 8'h30
`define OP2_CMP_IYD 8'h31
`define OP2_CMP_IXL 8'h32
`define OP2_CMP_IYL 8'h33
`define OP2_CMP_BIMM 8'hBC
`define FLAG_Z 0
`define FLAG_C 1
`define FLAG_V 2
`define FLAG_N 3
`define CUST_FLAG_BASE 4
`define RET_OFS_SHORT 16'h0002
`define RET_OFS_PREFIX 16'h0003
`define CALL_CYC_CZ_MIN 4'h4
`define CALL_CYC_CZ_MAX 4'h5
`define CALL_CYC_CZ_NOT 4'h2
`define CALL_CYC_SC_MIN 4'h5
`define CALL_CYC_SC_MAX 4'h6
`define CALL_CYC_SC_NOT 4'h3
`define SP_DEC_MIN 16'h0002
`define SP_DEC_MAX 16'h0003
`endif

/* logic/cond_eval.v */
// condition evaluator for both conditional call sets
`timescale 1ns/100ps
`include "cscc_regs.vh"
module cond_eval (
  input wire [1:0] cz_sel_i,
  input wire [3:0] sc_sel_i,
  input wire use_sc_i,
  input wire [7:0] flags_i,
  output reg taken_o
);
  // ===========================================
  // condition decode
  reg n;
  reg v;
  reg lt;
  // combinational select of carry/zero or signed/custom condition
  always @* begin
    n = flags_i[`FLAG_N];
    v = flags_i[`FLAG_V];
    lt = n ^ v;
    taken_o = 1'b0;
    if (!use_sc_i) begin
      case (cz_sel_i)
        2'b00: taken_o = flags_i[`FLAG_C];
        2'b01: taken_o = ~flags_i[`FLAG_C];
        2'b10: taken_o = flags_i[`FLAG_Z];
        default: taken_o = ~flags_i[`FLAG_Z];
      endcase
    end else begin
      case (sc_sel_i)
        4'h0: taken_o = lt;
        4'h1: taken_o = flags_i[`FLAG_Z] | lt;
        4'h2: taken_o = ~(flags_i[`FLAG_Z] | lt);
        4'h3: taken_o = ~lt;
        4'h4: taken_o = v;
        4'h5: taken_o = ~v;
        4'h6: taken_o = ~n;
        4'h7: taken_o = n;
        default: begin
          // custom flags, bit 2 of selector picks set or clear
          if (sc_sel_i[2])
            taken_o = ~flags_i[`CUST_FLAG_BASE + sc_sel_i[1:0]];
          else
            taken_o = flags_i[`CUST_FLAG_BASE + sc_sel_i[1:0]];
        end
      endcase
    end
  end
endmodule

/* logic/cmp_alu.v */
// 8-bit compare subtractor producing N, V, C, Z
`timescale 1ns/100ps
module cmp_alu (
  input wire [7:0] dst_i,
  input wire [7:0] src_i,
  output wire n_o,
  output wire v_o,
  output wire c_o,
  output wire z_o
);
  // ===========================================
  // subtraction with borrow out
  wire [8:0] diff;
  assign diff = {1'b0, dst_i} - {1'b0, src_i};
  assign n_o = diff[7];
  assign z_o = (diff[7:0] == 8'h00);
  assign c_o = diff[8];
  assign v_o = (dst_i[7] ^ src_i[7]) & (dst_i[7] ^ diff[7]);
endmodule

/* logic/cond_short_call_and_compare.v */
// sequencer for conditional short calls and 8-bit compares
`timescale 1ns/100ps
`include "cscc_regs.vh"
module cond_short_call_and_compare #(
  parameter banked_models = 1
) (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,               // clock enable, freezes all state when low
  input wire max_mode_i,         // maximum mode strap
  input wire start_i,            // begin one instruction at pc_i
  input wire [15:0] pc_i,        // instruction start address
  input wire [15:0] sp_i,        // stack pointer before the instruction
  input wire [7:0] acc_i,        // accumulator
  input wire [7:0] breg_i,       // second 8-bit register
  input wire [7:0] low_reg_i,    // low byte register used as signed index
  input wire [15:0] pointer_pair_i,
  input wire [15:0] first_index_i,
  input wire [15:0] second_index_i,
  input wire [7:0] base_page_reg_i,
  input wire [7:0] data_page_i,
  input wire [7:0] first_index_page_i,
  input wire [7:0] second_index_page_i,
  input wire [7:0] code_bank_i,
  input wire [7:0] new_code_bank_i,
  input wire [7:0] flags_i,      // {custom flags 3..0, N, V, C, Z}
  input wire [7:0] rdata_i,      // memory read data, valid in the cycle rd_o is high
  output reg [23:0] addr_o,      // bus address {page, offset}
  output reg [7:0] wdata_o,
  output reg rd_o,
  output reg wr_o,
  output reg done_o,             // instruction complete pulse
  output reg [15:0] pc_o,
  output reg [15:0] sp_o,
  output reg [7:0] code_bank_o,
  output reg [7:0] new_code_bank_o,
  output reg [7:0] flags_o,
  output reg [3:0] bus_cycles_o, // bus cycles the last instruction used
  output reg busy_o
);
  // ===========================================
  // state codes
  localparam st_idle = 3'd0;
  localparam st_fetch = 3'd1;
  localparam st_operand = 3'd2;
  localparam st_operand2 = 3'd3;
  localparam st_mem = 3'd4;
  localparam st_push = 3'd5;
  localparam st_finish = 3'd6;

  // ===========================================
  // sequencer registers
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [15:0] pc_reg;           // start address of current instruction
  reg [15:0] fetch_reg;        // next code byte address
  reg [7:0] op_reg;            // first opcode byte
  reg [7:0] op2_reg;           // second byte after prefix
  reg prefix_reg;              // prefixed form
  reg [7:0] opnd_reg;          // first operand byte
  reg [23:0] ea_reg;           // memory operand address
  reg [1:0] push_cnt_reg;      // stack bytes left to write
  reg [3:0] cyc_reg;           // bus cycles counted
  reg is_call_reg;
  reg [7:0] cmp_src_reg;       // subtrahend
  reg [7:0] cmp_dst_reg;       // minuend

  wire taken;
  wire cmp_n;
  wire cmp_v;
  wire cmp_c;
  wire cmp_z;
  wire banked_max;
  wire [15:0] ret_addr;
  wire [15:0] target;
  wire [15:0] disp_ext;

  assign banked_max = (banked_models != 0) & max_mode_i;
  // return address and target per call form
  assign ret_addr = pc_reg + (prefix_reg ? `RET_OFS_PREFIX : `RET_OFS_SHORT);
  assign disp_ext = {{8{opnd_reg[7]}}, opnd_reg};
  // target uses address of the displacement byte: start+1 or start+2
  assign target = ret_addr - 16'h0001 + disp_ext;

  // ===========================================
  // condition and subtractor
  cond_eval u_cond (
    .cz_sel_i(op_reg[1:0]),
    .sc_sel_i(op2_reg[3:0]),
    .use_sc_i(prefix_reg),
    .flags_i(flags_i),
    .taken_o(taken)
  );

  cmp_alu u_alu (
    .dst_i(cmp_dst_reg),
    .src_i(cmp_src_reg),
    .n_o(cmp_n),
    .v_o(cmp_v),
    .c_o(cmp_c),
    .z_o(cmp_z)
  );

  // ===========================================
  // index address helper: page from matching index register
  function [23:0] idx_addr;
    input sel_y;
    input [7:0] ofs;
    input [15:0] ix;
    input [15:0] iy;
    input [7:0] xp;
    input [7:0] yp;
    reg [15:0] base;
    begin
      base = sel_y ? iy : ix;
      idx_addr = {(sel_y ? yp : xp), base + {{8{ofs[7]}}, ofs}};
    end
  endfunction

  // ===========================================
  // main sequencer
  always @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= st_idle;
      pc_reg <= 16'h0000;
      fetch_reg <= 16'h0000;
      op_reg <= 8'h00;
      op2_reg <= 8'h00;
      prefix_reg <= 1'b0;
      opnd_reg <= 8'h00;
      ea_reg <= 24'h000000;
      push_cnt_reg <= 2'h0;
      cyc_reg <= 4'h0;
      is_call_reg <= 1'b0;
      cmp_src_reg <= 8'h00;
      cmp_dst_reg <= 8'h00;
      addr_o <= 24'h000000;
      wdata_o <= 8'h00;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      done_o <= 1'b0;
      pc_o <= 16'h0000;
      sp_o <= 16'h0000;
      code_bank_o <= 8'h00;
      new_code_bank_o <= 8'h00;
      flags_o <= 8'h00;
      bus_cycles_o <= 4'h0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      done_o <= 1'b0;
      case (state_reg)
        st_idle: begin
          if (start_i) begin
            // capture start, read first code byte
            pc_reg <= pc_i;
            fetch_reg <= pc_i + 16'h0001;
            addr_o <= {code_bank_i, pc_i};
            rd_o <= 1'b1;
            prefix_reg <= 1'b0;
            cyc_reg <= 4'h1;
            busy_o <= 1'b1;
            sp_o <= sp_i;
            code_bank_o <= code_bank_i;
            new_code_bank_o <= new_code_bank_i;
            flags_o <= flags_i;
            state_reg <= st_fetch;
          end
        end
        st_fetch: begin
          // opcode byte arrives; handle prefix
          if (!prefix_reg && rdata_i == `OP_PREFIX) begin
            prefix_reg <= 1'b1;
            addr_o <= {code_bank_o, fetch_reg};
            fetch_reg <= fetch_reg + 16'h0001;
            rd_o <= 1'b1;
            cyc_reg <= cyc_reg + 4'h1;
          end else begin
            if (prefix_reg)
              op2_reg <= rdata_i;
            else
              op_reg <= rdata_i;
            is_call_reg <= prefix_reg ? (rdata_i[7:4] == `OP_CALL_SC_HI)
                                      : (rdata_i[7:2] == `OP_CALL_CZ_HI);
            cmp_dst_reg <= (prefix_reg && rdata_i == `OP2_CMP_BIMM) ? breg_i : acc_i;
            if (!prefix_reg && (rdata_i == `OP_CMP_AA || rdata_i == `OP_CMP_AB)) begin
              // register source, no operand byte
              cmp_src_reg <= rdata_i[0] ? breg_i : acc_i;
              state_reg <= st_finish;
            end else begin
              addr_o <= {code_bank_o, fetch_reg};
              fetch_reg <= fetch_reg + 16'h0001;
              rd_o <= 1'b1;
              cyc_reg <= cyc_reg + 4'h1;
              state_reg <= st_operand;
            end
            // indirect forms need no operand byte: go straight to memory
            if (!prefix_reg && rdata_i == `OP_CMP_APTR) begin
              addr_o <= {(banked_models != 0) ? data_page_i : 8'h00, pointer_pair_i};
              fetch_reg <= fetch_reg;
              state_reg <= st_mem;
            end
            if (!prefix_reg && (rdata_i == `OP_CMP_AIX || rdata_i == `OP_CMP_AIY)) begin
              addr_o <= idx_addr(rdata_i[0], 8'h00, first_index_i, second_index_i,
                                 first_index_page_i, second_index_page_i);
              fetch_reg <= fetch_reg;
              state_reg <= st_mem;
            end
            if (prefix_reg && (rdata_i == `OP2_CMP_IXL || rdata_i == `OP2_CMP_IYL)) begin
              addr_o <= idx_addr(rdata_i[0], low_reg_i, first_index_i, second_index_i,
                                 first_index_page_i, second_index_page_i);
              fetch_reg <= fetch_reg;
              state_reg <= st_mem;
            end
          end
        end
        st_operand: begin
          opnd_reg <= rdata_i;
          if (is_call_reg) begin
            if (taken) begin
              push_cnt_reg <= banked_max ? 2'h3 : 2'h2;
              state_reg <= st_push;
            end else begin
              // untaken: no stack access, SP kept
              pc_o <= pc_reg + (prefix_reg ? `RET_OFS_PREFIX : `RET_OFS_SHORT);
              if (banked_models != 0)
                new_code_bank_o <= code_bank_o;
              bus_cycles_o <= prefix_reg ? `CALL_CYC_SC_NOT : `CALL_CYC_CZ_NOT;
              done_o <= 1'b1;
              busy_o <= 1'b0;
              state_reg <= st_idle;
            end
          end else if (!prefix_reg && op_reg == `OP_CMP_AIMM) begin
            cmp_src_reg <= rdata_i;
            state_reg <= st_finish;
          end else if (prefix_reg && op2_reg == `OP2_CMP_BIMM) begin
            cmp_src_reg <= rdata_i;
            state_reg <= st_finish;
          end else if (!prefix_reg && op_reg == `OP_CMP_ASHORT) begin
            addr_o <= {(banked_models != 0) ? data_page_i : 8'h00,
                       base_page_reg_i, rdata_i};
            rd_o <= 1'b1;
            cyc_reg <= cyc_reg + 4'h1;
            state_reg <= st_mem;
          end else if (!prefix_reg && op_reg == `OP_CMP_ALONG) begin
            // low byte now, high byte next
            addr_o <= {code_bank_o, fetch_reg};
            fetch_reg <= fetch_reg + 16'h0001;
            rd_o <= 1'b1;
            cyc_reg <= cyc_reg + 4'h1;
            state_reg <= st_operand2;
          end else if (prefix_reg && (op2_reg == `OP2_CMP_IXD || op2_reg == `OP2_CMP_IYD)) begin
            addr_o <= idx_addr(op2_reg[0], rdata_i, first_index_i, second_index_i,
                               first_index_page_i, second_index_page_i);
            rd_o <= 1'b1;
            cyc_reg <= cyc_reg + 4'h1;
            state_reg <= st_mem;
          end else begin
            // unsupported opcode: finish with no effect
            done_o <= 1'b1;
            busy_o <= 1'b0;
            bus_cycles_o <= cyc_reg;
            state_reg <= st_idle;
          end
        end
        st_operand2: begin
          addr_o <= {(banked_models != 0) ? data_page_i : 8'h00, rdata_i, opnd_reg};
          rd_o <= 1'b1;
          cyc_reg <= cyc_reg + 4'h1;
          state_reg <= st_mem;
        end
        st_mem: begin
          // memory operand read issued last cycle; every entry path sets rd before coming here
          if (!rd_o) begin
            rd_o <= 1'b1;
            cyc_reg <= cyc_reg + 4'h1;
          end else begin
            cmp_src_reg <= rdata_i;
            state_reg <= st_finish;
          end
        end
        st_push: begin
          // write bank (max), then PC high, then PC low, downward from SP
          if (push_cnt_reg != 2'h0) begin
            wr_o <= 1'b1;
            addr_o <= {8'h00, sp_o - 16'h0001};
            sp_o <= sp_o - 16'h0001;
            if (push_cnt_reg == 2'h3)
              wdata_o <= code_bank_o;
            else if (push_cnt_reg == 2'h2)
              wdata_o <= ret_addr[15:8];
            else
              wdata_o <= ret_addr[7:0];
            push_cnt_reg <= push_cnt_reg - 2'h1;
          end else begin
            pc_o <= target;
            if (banked_models != 0)
              code_bank_o <= new_code_bank_o;
            if (prefix_reg)
              bus_cycles_o <= max_mode_i ? `CALL_CYC_SC_MAX : `CALL_CYC_SC_MIN;
            else
              bus_cycles_o <= max_mode_i ? `CALL_CYC_CZ_MAX : `CALL_CYC_CZ_MIN;
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state_reg <= st_idle;
          end
        end
        st_finish: begin
          // only N, V, C, Z change; operands are never written
          flags_o[`FLAG_N] <= cmp_n;
          flags_o[`FLAG_V] <= cmp_v;
          flags_o[`FLAG_C] <= cmp_c;
          flags_o[`FLAG_Z] <= cmp_z;
          pc_o <= fetch_reg;
          bus_cycles_o <= cyc_reg;
          done_o <= 1'b1;
          busy_o <= 1'b0;
          state_reg <= st_idle;
        end
        default: state_reg <= st_idle;
      endcase
    end
  end
endmodule

/* sim/call_cmp_checker.sv */
// concurrent checks on the call and compare sequencer ports
`timescale 1ns/100ps
module call_cmp_checker #(
  parameter banked_models = 1
) (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire max_mode_i,
  input wire start_i,
  input wire [15:0] sp_i,
  input wire [7:0] flags_i,
  input wire [7:0] new_code_bank_i,
  input wire [23:0] addr_o,
  input wire wr_o,
  input wire done_o,
  input wire [15:0] sp_o,
  input wire [7:0] code_bank_o,
  input wire [7:0] flags_o,
  input wire [3:0] bus_cycles_o,
  input wire busy_o
);
  logic [2:0] wcount_reg; // stack writes seen in this instruction
  logic [2:0] wcount_next;
  // ==========================================
  // write counter, cleared when a start is taken
  always @* begin
    wcount_next = wcount_reg;
    if (start_i && !busy_o) wcount_next = 3'h0;
    else if (wr_o) wcount_next = wcount_reg + 3'h1;
  end
  // frozen with the design while ce_i is low
  always @(posedge clk_i) begin
    if (reset_i) wcount_reg <= 3'h0;
    else if (ce_i) wcount_reg <= wcount_next;
  end
  // ==========================================
  // properties
  default clocking clk_edge @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_accept;
    ce_i && start_i && !busy_o;
  endsequence
  sequence s_stack_call;
    done_o && wcount_reg != 3'h0;
  endsequence
  AST_DONE_BOUND: assert property (s_accept |-> ##[1:40] done_o)
    else $error("instruction did not complete in time");
  AST_UNTAKEN_NO_STACK: assert property (done_o && bus_cycles_o <= 4'h3 |-> wcount_reg == 3'h0)
    else $error("short instruction wrote memory");
  AST_PUSH_COUNT: assert property (s_stack_call |-> wcount_reg == ((banked_models != 0 && max_mode_i) ? 3'h3 : 3'h2))
    else $error("wrong number of stack pushes");
  AST_SP_MOVE: assert property (s_stack_call |-> sp_o == sp_i - {13'h0, wcount_reg})
    else $error("stack pointer not moved by push count");
  AST_CALL_CYCLES: assert property (s_stack_call |-> bus_cycles_o == {1'b0, wcount_reg} + 4'h2
      || bus_cycles_o == {1'b0, wcount_reg} + 4'h3)
    else $error("taken call bus cycle count wrong");
  AST_BANK_LOAD: assert property (s_stack_call |-> banked_models == 0 || code_bank_o == new_code_bank_i)
    else $error("code bank not loaded from new bank");
  AST_CALL_FLAGS: assert property (s_stack_call |-> flags_o == flags_i)
    else $error("call changed flags");
  AST_CUSTOM_FLAGS: assert property (done_o |-> flags_o[7:4] == flags_i[7:4])
    else $error("custom flags changed");
  AST_STACK_ADDR: assert property (wr_o |-> addr_o == {8'h00, sp_i - 16'h1 - {13'h0, wcount_reg}})
    else $error("push address out of order");
endmodule
bind cond_short_call_and_compare call_cmp_checker #(.banked_models(banked_models)) chk (
  .clk_i, .reset_i, .ce_i, .max_mode_i, .start_i, .sp_i, .flags_i, .new_code_bank_i,
  .addr_o, .wr_o, .done_o, .sp_o, .code_bank_o, .flags_o, .bus_cycles_o, .busy_o);

/* sim/mem_model.sv */
// behavioural program and data memory on the cpu bus
`timescale 1ns/100ps
module mem_model (
  input wire clk_i,
  input wire ce_i,
  input wire [23:0] addr_i,
  input wire [7:0] wdata_i,
  input wire rd_i,
  input wire wr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535]; // byte store, page bits not decoded
  logic [23:0] last_ra = 24'h0; // latest read address with page
  logic [23:0] last_wa = 24'h0; // latest write address with page
  integer reads = 0; // accepted reads
  integer writes = 0; // accepted writes
  logic [7:0] idle_q = 8'h00; // shown while no read is asked, flips each enabled cycle
  // ==========================================
  // read data stands while rd_i is high; the design takes it at the edge that ends the read
  assign rdata_o = rd_i ? mem[addr_i[15:0]] : idle_q;
  always @(posedge clk_i) begin
    if (ce_i) begin
      idle_q <= ~idle_q;
      if (rd_i) begin
        last_ra <= addr_i;
        reads <= reads + 1;
      end
      if (wr_i) begin
        mem[addr_i[15:0]] <= wdata_i;
        last_wa <= addr_i;
        writes <= writes + 1;
      end
    end
  end
endmodule

/* sim/test_cond_short_call_and_compare.sv */
// self-checking bench for the call and compare sequencer
`timescale 1ns/100ps
module test_cond_short_call_and_compare;
  logic clk_i = 0, reset_i = 1, ce_i = 1, max_mode_i = 0, start_i = 0;
  logic [15:0] pc_i = 16'h9000, sp_i = 16'h0000, pointer_pair_i = 16'h4321;
  logic [15:0] first_index_i = 16'h5000, second_index_i = 16'h6000;
  logic [7:0] acc_i = 8'h00, breg_i = 8'h00, low_reg_i = 8'hF0, base_page_reg_i = 8'h12;
  logic [7:0] data_page_i = 8'h03, first_index_page_i = 8'h05, second_index_page_i = 8'h06;
  logic [7:0] code_bank_i = 8'h01, new_code_bank_i = 8'h02, flags_i = 8'h00;
  wire [7:0] rdata_i, wdata_o, code_bank_o, new_code_bank_o, flags_o;
  wire [23:0] addr_o;
  wire [15:0] pc_o, sp_o;
  wire [3:0] bus_cycles_o;
  wire rd_o, wr_o, done_o, busy_o;
  integer failures = 0, samples_checked = 0;
  integer r, m, c, k, r0, w0, n;
  logic t, pre; // call taken, prefixed form
  logic [7:0] disp; // call displacement
  logic [15:0] ret; // expected return address
  typedef struct packed {
    logic [7:0] b0, b1, b2;
    logic [23:0] ea;
    logic [7:0] dst, src;
    logic [3:0] nvcz;
  } row_t;
  row_t rows [0:12]; // compare cases: bytes, operand address, operands, flags
  row_t rw;
  always #2 clk_i = ~clk_i;
  cond_short_call_and_compare #(.banked_models(1)) uut (
    .clk_i, .reset_i, .ce_i, .max_mode_i, .start_i, .pc_i, .sp_i, .acc_i, .breg_i,
    .low_reg_i, .pointer_pair_i, .first_index_i, .second_index_i, .base_page_reg_i,
    .data_page_i, .first_index_page_i, .second_index_page_i, .code_bank_i,
    .new_code_bank_i, .flags_i, .rdata_i, .addr_o, .wdata_o, .rd_o, .wr_o, .done_o,
    .pc_o, .sp_o, .code_bank_o, .new_code_bank_o, .flags_o, .bus_cycles_o, .busy_o);
  mem_model mem (.clk_i, .ce_i, .addr_i(addr_o), .wdata_i(wdata_o), .rd_i(rd_o),
    .wr_i(wr_o), .rdata_o(rdata_i));
  // ==========================================
  // helpers
  task check(input logic [23:0] seen, input logic [23:0] want);
    begin
      samples_checked++;
      if (seen !== want) begin
        failures++;
        $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // load code at pc_i, start at this falling edge, optional ce gap
  task exec(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input logic st);
    integer i;
    begin
      mem.mem[pc_i] = b0;
      mem.mem[pc_i + 16'h1] = b1;
      mem.mem[pc_i + 16'h2] = b2;
      r0 = mem.reads;
      w0 = mem.writes;
      start_i = 1;
      @(negedge clk_i) start_i = 0;
      for (i = 0; i < 40 && done_o !== 1'b1; i++) begin
        ce_i = !(st && i >= 1 && i < 4);
        @(negedge clk_i);
      end
      ce_i = 1;
      if (done_o !== 1'b1) begin
        failures++;
        print_verdict;
      end
      // let the done cycle pass: inputs must still stand when the checker samples it
      @(negedge clk_i);
    end
  endtask
  // expected call condition from selector index and flags
  function logic want_taken(input integer sel, input logic [7:0] f);
    logic nv;
    begin
      nv = f[3] ^ f[2];
      case (sel)
        0: want_taken = f[1];
        1: want_taken = !f[1];
        2: want_taken = f[0];
        3: want_taken = !f[0];
        4: want_taken = nv;
        5: want_taken = f[0] | nv;
        6: want_taken = !(f[0] | nv);
        7: want_taken = !nv;
        8: want_taken = f[2];
        9: want_taken = !f[2];
        10: want_taken = !f[3];
        11: want_taken = f[3];
        default: want_taken = (sel < 16) ? f[sel - 8] : !f[sel - 12];
      endcase
    end
  endfunction
  // ==========================================
  // main sequence
  initial begin
    rows[0] = {8'h30, 8'h00, 8'h00, 24'h000000, 8'h1D, 8'h1D, 4'h1};
    rows[1] = {8'h31, 8'h00, 8'h00, 24'h000000, 8'h74, 8'h2A, 4'h0};
    rows[2] = {8'h32, 8'h59, 8'h00, 24'h000000, 8'h3C, 8'h59, 4'hA};
    rows[3] = {8'h33, 8'h44, 8'h00, 24'h031244, 8'hC3, 8'h62, 4'h4};
    rows[4] = {8'h34, 8'h78, 8'h56, 24'h035678, 8'h74, 8'h2A, 4'h0};
    rows[5] = {8'h35, 8'h00, 8'h00, 24'h034321, 8'h1D, 8'h1D, 4'h1};
    rows[6] = {8'h36, 8'h00, 8'h00, 24'h055000, 8'h3C, 8'h59, 4'hA};
    rows[7] = {8'h37, 8'h00, 8'h00, 24'h066000, 8'hC3, 8'h62, 4'h4};
    rows[8] = {8'hCE, 8'h30, 8'h80, 24'h054F80, 8'h74, 8'h2A, 4'h0};
    rows[9] = {8'hCE, 8'h31, 8'h7F, 24'h06607F, 8'h1D, 8'h1D, 4'h1};
    rows[10] = {8'hCE, 8'h32, 8'h00, 24'h054FF0, 8'h3C, 8'h59, 4'hA};
    rows[11] = {8'hCE, 8'h33, 8'h00, 24'h065FF0, 8'hC3, 8'h62, 4'h4};
    rows[12] = {8'hCE, 8'hBC, 8'h2A, 24'h000000, 8'h74, 8'h2A, 4'h0};
    repeat (10) @(negedge clk_i);
    reset_i = 0;
    check({pc_o, busy_o, done_o, rd_o, wr_o}, 24'h0);
    // compares, every odd row with a clock-enable gap
    for (r = 0; r < 13; r++) begin
      rw = rows[r];
      acc_i = rw.dst;
      breg_i = (rw.b1 == 8'hBC) ? rw.dst : rw.src;
      mem.mem[rw.ea[15:0]] = rw.src;
      flags_i = 8'hA5;
      exec(rw.b0, rw.b1, rw.b2, r[0]);
      check(flags_o, {4'hA, rw.nvcz});
      if (rw.ea != 24'h0) check(mem.last_ra, rw.ea);
      check(24'(mem.writes - w0), 24'h0);
      check(bus_cycles_o, 24'(mem.reads - r0));
    end
    {pointer_pair_i, first_index_i, second_index_i, low_reg_i} = ~{pointer_pair_i,
      first_index_i, second_index_i, low_reg_i};
    // every call condition, both modes, three flag patterns
    for (m = 0; m < 2; m++)
      for (c = 0; c < 20; c++)
        for (k = 0; k < 3; k++) begin
          max_mode_i = m[0];
          flags_i = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'h5A;
          sp_i = k[0] ? 16'h8001 : 16'h0000;
          disp = k[0] ? 8'h80 : 8'h7F;
          code_bank_i = c[7:0];
          new_code_bank_i = ~c[7:0];
          t = want_taken(c, flags_i);
          pre = (c >= 4);
          ret = pc_i + (pre ? 16'h0003 : 16'h0002);
          n = t ? (m ? 3 : 2) : 0;
          mem.mem[sp_i - 16'h1] = 8'hEE;
          mem.mem[sp_i - 16'h2] = 8'hEE;
          mem.mem[sp_i - 16'h3] = 8'hEE;
          exec(pre ? 8'hCE : {6'h38, c[1:0]}, pre ? {4'hF, c[3:0] - 4'h4} : disp, disp, k == 2);
          check(pc_o, t ? 16'(pc_i + (pre ? 16'h2 : 16'h1) + {{8{disp[7]}}, disp}) : ret);
          check(sp_o, 16'(sp_i - n[15:0]));
          check(bus_cycles_o, (pre ? 4'h3 : 4'h2) + (t ? 4'h2 + m[3:0] : 4'h0));
          check(flags_o, flags_i);
          check(code_bank_o, t ? new_code_bank_i : code_bank_i);
          check(new_code_bank_o, t ? new_code_bank_i : code_bank_i);
          check(24'(mem.writes - w0), 24'(n));
          if (t) begin
            check(mem.last_wa, {8'h00, sp_i - n[15:0]});
            check(mem.mem[sp_i - 16'h1], m ? code_bank_i : ret[15:8]);
            check(mem.mem[sp_i - 16'h2], m ? ret[15:8] : ret[7:0]);
            if (m) check(mem.mem[sp_i - 16'h3], ret[7:0]);
          end
        end
    // unknown opcode ends without stack traffic
    exec(8'h00, 8'h00, 8'h00, 1'b0);
    check(24'(mem.writes - w0), 24'h0);
    // reset in mid-instruction, then a compare recovers
    start_i = 1;
    @(negedge clk_i) start_i = 0;
    @(negedge clk_i) reset_i = 1;
    @(negedge clk_i) reset_i = 0;
    check({busy_o, done_o, wr_o, rd_o}, 24'h0);
    acc_i = 8'h3C;
    exec(8'h32, 8'h59, 8'h00, 1'b0);
    check(flags_o[3:0], 4'hA);
    print_verdict;
  end
endmodule
